// ==== hw/scg_defs.svh ====
/*
  register map, reset values, command codes and field positions of the
  two-wire control slave with its group-write engine.
  assumes: included by bare name from the top module only.
*/
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define SCG_A_PRIM_ID   16'h3100
`define SCG_A_SEC_ID    16'h3101
`define SCG_A_SYS_CTRL  16'h301c
`define SCG_A_GRP_CMD   16'h3208
`define SCG_A_G0_PER    16'h3209
`define SCG_A_G1_PER    16'h320a
`define SCG_A_SW_CTRL   16'h320b
`define SCG_A_ACT_GRP   16'h320d
`define SCG_A_G0_FCNT   16'h320e
`define SCG_A_G1_FCNT   16'h320f
`define SCG_A_G0_START  16'h3280
`define SCG_A_G1_START  16'h3281

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define SCG_R_PRIM_ID   8'hc0
`define SCG_R_SEC_ID    8'he0
`define SCG_R_SW_CTRL   8'h01
`define SCG_R_G0_START  8'h00
`define SCG_R_G1_START  8'h04
`define SCG_R_ZERO      8'h00

// -----------------------------------------------------------------
// group commands and fields
// -----------------------------------------------------------------
`define SCG_C_REC_START 4'h0
`define SCG_C_REC_END   4'h1
`define SCG_C_LAUNCH    4'ha
`define SCG_C_IMMEDIATE 4'he
`define SCG_B_CLK_KEEP  5
`define SCG_B_ALT_STOP  1
`define SCG_B_SW_REPEAT 3
`define SCG_B_SW_EN     2
`define SCG_BUF_DEPTH   8'h80

`endif

// ==== hw/scg_pkg.sv ====
/*
  types shared by the control slave: bus states and write carriers.
  assumes: compiled before the top module.
*/
`default_nettype none

package scg_pkg;
  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK} scg_bus_st_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } scg_entry_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } scg_wr_t;
endpackage : scg_pkg

`default_nettype wire

// ==== hw/scg_top.sv ====
/*
  two-wire control slave with a two-bank group-write engine.
  assumes: serial pins come from a host on another clock and are synchronised
  here; frame_clk_i is the sensor timing clock, frame_start_i and long_blank_i
  are levels in that domain; the open-drain data pin is resolved outside.
*/
// Functional notes
// - answer to two programmable slave identifiers, defaults c0 and e0
// - transfers carry 7-bit address, 16-bit sub-address, 8-bit data
// - sub-address pointer advances by one after every byte read or written
// - random read is dummy sub-address write, repeated start, then read
// - read without sub-address write returns data at last used pointer
// - host acknowledge continues read at next address, nack ends burst
// - write is address, two sub-address bytes, data, each acknowledged
// - sequential write stores each further byte at next sub-address
// - registers of one group take effect together at frame boundary
// - group buffer holds two groups in 128 entries, 64 each by default
// - group buffer start is start nibble followed by four zero bits
// - group logic may stop during long blanking unless keep bit set
// - command 0 starts recording into a bank, command 1 ends it
// - launch command a applies the bank at the next frame boundary
// - command e applies the bank at once; other codes are ignored
// - bank 0 starts at entry 00, bank 1 at entry 40 by default
// - switch control 0d then launch a0 alternates banks per frame counts
// - switch control holds repeat, enable and second-bank select fields
// - read-only active bank status and a frame counter per bank
// - shutdown reset returns all registers and group state to defaults
`default_nettype none
`include "scg_defs.svh"

module scg_top (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        frame_clk_i,
  input  wire logic        frame_start_i,
  input  wire logic        long_blank_i,
  input  wire logic        hardware_shutdown_reset_n_i,
  input  wire logic        serial_clock_line_i,
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe_o,
  output logic             group_active_o,
  output var scg_pkg::scg_wr_t live_wr_o
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // bank start in entries; the nibble reaches past 128, indexes stop there
  function automatic logic [7:0] grp_base(input logic [7:0] start);
    return {start[3:0], 4'h0};
  endfunction : grp_base

  // a bank ends where the other begins, or at the buffer end
  function automatic logic [7:0] grp_end(input logic [7:0] me, input logic [7:0] ot);
    return (grp_base(ot) > grp_base(me)) ? grp_base(ot) : `SCG_BUF_DEPTH;
  endfunction : grp_end

  // -----------------------------------------------------------------
  // frame domain: edge to toggle, blank level registered
  // -----------------------------------------------------------------
  logic f_rst1_reg, f_rst2_reg, f_start_q_reg, f_tog_reg, f_blank_reg;

  // reset of the frame domain is rst_i brought over by two flops
  always_ff @(posedge frame_clk_i) begin
    f_rst1_reg <= rst_i;
    f_rst2_reg <= f_rst1_reg;
  end

  // each frame start flips the toggle so a slow clock_i side never misses it
  always_ff @(posedge frame_clk_i) begin
    if (f_rst2_reg) begin
      f_start_q_reg <= 1'b0;
      f_tog_reg     <= 1'b0;
      f_blank_reg   <= 1'b0;
    end else begin
      f_start_q_reg <= frame_start_i;
      f_blank_reg   <= long_blank_i;
      if (frame_start_i && !f_start_q_reg) begin
        f_tog_reg <= ~f_tog_reg;
      end
    end
  end

  // -----------------------------------------------------------------
  // synchronisers into clock_i
  // -----------------------------------------------------------------
  logic shut1_reg, shut2_reg, scl1_reg, scl2_reg, scl_q_reg, sda1_reg, sda2_reg, sda_q_reg;
  logic tog1_reg, tog2_reg, tog_q_reg, blank1_reg, blank2_reg;
  logic rst_any;

  // shutdown pin held low keeps everything at defaults
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shut1_reg <= 1'b0;
      shut2_reg <= 1'b0;
    end else begin
      shut1_reg <= hardware_shutdown_reset_n_i;
      shut2_reg <= shut1_reg;
    end
  end
  assign rst_any = rst_i | ~shut2_reg;

  // the *_q flops feed edge detectors; they read the second stage only
  always_ff @(posedge clock_i) begin
    if (rst_any) begin
      {scl1_reg, scl2_reg, scl_q_reg} <= 3'h7;
      {sda1_reg, sda2_reg, sda_q_reg} <= 3'h7;
      {tog1_reg, tog2_reg, tog_q_reg} <= 3'h0;
      {blank1_reg, blank2_reg}        <= 2'h0;
    end else begin
      {scl1_reg, scl2_reg, scl_q_reg} <= {serial_clock_line_i, scl1_reg, scl2_reg};
      {sda1_reg, sda2_reg, sda_q_reg} <= {serial_data_line_i, sda1_reg, sda2_reg};
      {tog1_reg, tog2_reg, tog_q_reg} <= {f_tog_reg, tog1_reg, tog2_reg};
      {blank1_reg, blank2_reg}        <= {f_blank_reg, blank1_reg};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl2_reg & ~scl_q_reg;
  assign scl_fall  = ~scl2_reg & scl_q_reg;
  assign bus_start = scl2_reg & scl_q_reg & ~sda2_reg & sda_q_reg;
  assign bus_stop  = scl2_reg & scl_q_reg & sda2_reg & ~sda_q_reg;

  // -----------------------------------------------------------------
  // serial engine
  // -----------------------------------------------------------------
  scg_pkg::scg_bus_st_t st_reg;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  idx_reg;
  logic [7:0]  sh_reg, tx_sh_reg, rd_data, rx_byte;
  logic [15:0] ptr_reg;
  logic        rd_mode_reg, ack_pend_reg, oe_reg, rx_done, id_hit, bus_wr;
  logic [7:0]  prim_id_reg, sec_id_reg;

  assign rx_byte = {sh_reg[6:0], sda2_reg};
  assign rx_done = (st_reg == scg_pkg::BUS_RX) && scl_rise && (bit_cnt_reg == 4'h7);
  assign id_hit  = (rx_byte[7:1] == prim_id_reg[7:1]) ||
                   (rx_byte[7:1] == sec_id_reg[7:1]);
  assign bus_wr  = rx_done && !rd_mode_reg && (idx_reg == 2'h3);

  // receive on rising clock, drive on falling; start restarts, stop idles
  always_ff @(posedge clock_i) begin
    if (rst_any) begin
      st_reg       <= scg_pkg::BUS_IDLE;
      bit_cnt_reg  <= 4'h0;
      idx_reg      <= 2'h0;
      sh_reg       <= 8'h00;
      tx_sh_reg    <= 8'h00;
      ptr_reg      <= 16'h0000;
      rd_mode_reg  <= 1'b0;
      ack_pend_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else if (bus_start) begin
      st_reg       <= scg_pkg::BUS_RX; // repeated start too
      bit_cnt_reg  <= 4'h0;
      idx_reg      <= 2'h0;
      ack_pend_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else if (bus_stop) begin
      st_reg <= scg_pkg::BUS_IDLE;
      oe_reg <= 1'b0;
    end else begin
      case (st_reg)
        scg_pkg::BUS_RX: begin
          if (scl_rise) begin
            sh_reg      <= rx_byte;
            bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : bit_cnt_reg + 4'h1;
          end
          if (rx_done) begin
            idx_reg <= (idx_reg == 2'h3) ? 2'h3 : idx_reg + 2'h1;
            if (idx_reg == 2'h0) begin
              rd_mode_reg <= rx_byte[0];
              if (id_hit) begin
                ack_pend_reg <= 1'b1;
              end else begin
                st_reg <= scg_pkg::BUS_IDLE; // leave the line released
              end
            end else begin
              ack_pend_reg <= 1'b1;
            end
            if (idx_reg == 2'h1) begin
              ptr_reg[15:8] <= rx_byte;
            end
            if (idx_reg == 2'h2) begin
              ptr_reg[7:0] <= rx_byte;
            end
            if (bus_wr) begin
              ptr_reg <= ptr_reg + 16'h0001;
            end
          end
          if (scl_fall && ack_pend_reg) begin
            oe_reg       <= 1'b1;
            ack_pend_reg <= 1'b0;
            st_reg       <= scg_pkg::BUS_RX_ACK;
          end
        end
        scg_pkg::BUS_RX_ACK: begin
          if (scl_fall) begin
            if (rd_mode_reg) begin
              st_reg      <= scg_pkg::BUS_TX; // data from current pointer
              oe_reg      <= ~rd_data[7];
              tx_sh_reg   <= {rd_data[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
            end else begin
              st_reg      <= scg_pkg::BUS_RX;
              oe_reg      <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
        end
        scg_pkg::BUS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              oe_reg <= 1'b0;
              st_reg <= scg_pkg::BUS_TX_ACK;
            end else if (bit_cnt_reg == 4'h0) begin
              oe_reg      <= ~rd_data[7];
              tx_sh_reg   <= {rd_data[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
            end else begin
              oe_reg      <= ~tx_sh_reg[7];
              tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        scg_pkg::BUS_TX_ACK: begin
          if (scl_rise) begin
            ptr_reg <= ptr_reg + 16'h0001;
            if (!sda2_reg) begin
              st_reg      <= scg_pkg::BUS_TX; // next byte
              bit_cnt_reg <= 4'h0;
            end else begin
              st_reg <= scg_pkg::BUS_IDLE; // nack ends the burst
            end
          end
        end
        default: begin
          st_reg <= scg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // live registers and group buffer
  // -----------------------------------------------------------------
  logic [7:0] ctrl_reg, g0_per_reg, g1_per_reg, sw_reg, st0_reg, st1_reg;
  logic [7:0] scratch_mem [0:255];
  scg_pkg::scg_entry_t buf_mem [0:127];
  logic       rec_on_reg, rec_grp_reg, pend_reg, pend_grp_reg, pend_alt_reg;
  logic       ap_busy_reg, act_reg, alt_on_reg;
  logic [7:0] cnt_reg [0:1];
  logic [7:0] fc_reg [0:1];
  logic [7:0] ap_idx_reg, ap_end_reg, rec_addr, rec_lim, per_act, ap_b;
  logic       cmd_wr, bus_live, ap_go, fp_g, alt_sw, imm, ap_start, ap_g, g_ok;
  scg_pkg::scg_wr_t lw;

  assign cmd_wr   = bus_wr && (ptr_reg == `SCG_A_GRP_CMD);
  assign g_ok     = (rx_byte[3:1] == 3'h0);
  assign bus_live = bus_wr && !cmd_wr && !rec_on_reg;
  assign ap_go    = ap_busy_reg && !bus_live;
  // without the keep bit, frame events in long blanking are not seen
  assign fp_g     = (tog2_reg ^ tog_q_reg) &&
                    (ctrl_reg[`SCG_B_CLK_KEEP] || !blank2_reg);
  assign per_act  = act_reg ? g1_per_reg : g0_per_reg;
  assign alt_sw   = fp_g && !pend_reg && alt_on_reg &&
                    ((fc_reg[act_reg] + 8'h01) >= ((per_act == 8'h00) ? 8'h01 : per_act));
  assign imm      = cmd_wr && (rx_byte[7:4] == `SCG_C_IMMEDIATE) && g_ok;
  assign ap_start = imm || (fp_g && pend_reg) || alt_sw;
  assign ap_g     = imm ? rx_byte[0] : ((fp_g && pend_reg) ? pend_grp_reg :
                    (act_reg ? 1'b0 : sw_reg[0]));
  assign ap_b     = grp_base(ap_g ? st1_reg : st0_reg);
  assign rec_addr = grp_base(rec_grp_reg ? st1_reg : st0_reg) + cnt_reg[rec_grp_reg];
  assign rec_lim  = rec_grp_reg ? grp_end(st1_reg, st0_reg) : grp_end(st0_reg, st1_reg);

  // one write port: bus writes win, a replay waits a cycle behind them
  always_comb begin
    lw = '0;
    if (bus_live) begin
      lw = {1'b1, ptr_reg, rx_byte};
    end else if (ap_go) begin
      lw = {1'b1, buf_mem[ap_idx_reg[6:0]].addr, buf_mem[ap_idx_reg[6:0]].data};
    end
  end

  // live register store; the read-only addresses ignore writes
  always_ff @(posedge clock_i) begin
    if (rst_any) begin
      prim_id_reg <= `SCG_R_PRIM_ID;
      sec_id_reg  <= `SCG_R_SEC_ID;
      ctrl_reg    <= `SCG_R_ZERO;
      g0_per_reg  <= `SCG_R_ZERO;
      g1_per_reg  <= `SCG_R_ZERO;
      sw_reg      <= `SCG_R_SW_CTRL;
      st0_reg     <= `SCG_R_G0_START;
      st1_reg     <= `SCG_R_G1_START;
      for (int i = 0; i < 256; i++) begin
        scratch_mem[i] <= `SCG_R_ZERO;
      end
    end else if (lw.valid) begin
      case (lw.addr)
        `SCG_A_PRIM_ID:  prim_id_reg <= lw.data;
        `SCG_A_SEC_ID:   sec_id_reg  <= lw.data;
        `SCG_A_SYS_CTRL: ctrl_reg    <= lw.data;
        `SCG_A_G0_PER:   g0_per_reg  <= lw.data;
        `SCG_A_G1_PER:   g1_per_reg  <= lw.data;
        `SCG_A_SW_CTRL:  sw_reg      <= lw.data;
        `SCG_A_G0_START: st0_reg     <= lw.data;
        `SCG_A_G1_START: st1_reg     <= lw.data;
        `SCG_A_GRP_CMD, `SCG_A_ACT_GRP, `SCG_A_G0_FCNT, `SCG_A_G1_FCNT: begin
        end
        default:         scratch_mem[lw.addr[7:0]] <= lw.data;
      endcase
    end
  end

  // read view at the pointer; command reads back as zero
  always_comb begin
    case (ptr_reg)
      `SCG_A_PRIM_ID:  rd_data = prim_id_reg;
      `SCG_A_SEC_ID:   rd_data = sec_id_reg;
      `SCG_A_SYS_CTRL: rd_data = ctrl_reg;
      `SCG_A_GRP_CMD:  rd_data = `SCG_R_ZERO;
      `SCG_A_G0_PER:   rd_data = g0_per_reg;
      `SCG_A_G1_PER:   rd_data = g1_per_reg;
      `SCG_A_SW_CTRL:  rd_data = sw_reg;
      `SCG_A_ACT_GRP:  rd_data = {7'h00, act_reg};
      `SCG_A_G0_FCNT:  rd_data = fc_reg[0];
      `SCG_A_G1_FCNT:  rd_data = fc_reg[1];
      `SCG_A_G0_START: rd_data = st0_reg;
      `SCG_A_G1_START: rd_data = st1_reg;
      default:         rd_data = scratch_mem[ptr_reg[7:0]];
    endcase
  end

  // recording into the bank buffer; entries past the bank end are dropped
  always_ff @(posedge clock_i) begin
    if (bus_wr && !cmd_wr && rec_on_reg && (rec_addr < rec_lim)) begin
      buf_mem[rec_addr[6:0]] <= {ptr_reg, rx_byte};
    end
  end

  // -----------------------------------------------------------------
  // group engine
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_any) begin
      rec_on_reg   <= 1'b0;
      rec_grp_reg  <= 1'b0;
      pend_reg     <= 1'b0;
      pend_grp_reg <= 1'b0;
      pend_alt_reg <= 1'b0;
      ap_busy_reg  <= 1'b0;
      ap_idx_reg   <= 8'h00;
      ap_end_reg   <= 8'h00;
      act_reg      <= 1'b0;
      alt_on_reg   <= 1'b0;
      cnt_reg      <= '{default: 8'h00};
      fc_reg       <= '{default: 8'h00};
    end else begin
      if (cmd_wr && g_ok) begin
        case (rx_byte[7:4])
          `SCG_C_REC_START: begin
            rec_on_reg          <= 1'b1;
            rec_grp_reg         <= rx_byte[0];
            cnt_reg[rx_byte[0]] <= 8'h00;
          end
          `SCG_C_REC_END: rec_on_reg <= 1'b0;
          `SCG_C_LAUNCH: begin
            pend_reg     <= 1'b1;
            pend_grp_reg <= rx_byte[0];
            pend_alt_reg <= sw_reg[`SCG_B_SW_EN];
          end
          default: begin
          end
        endcase
      end else if (bus_wr && !cmd_wr && rec_on_reg && (rec_addr < rec_lim)) begin
        cnt_reg[rec_grp_reg] <= cnt_reg[rec_grp_reg] + 8'h01;
      end
      if (fp_g) begin
        fc_reg[act_reg] <= fc_reg[act_reg] + 8'h01;
      end
      if (fp_g && pend_reg) begin
        pend_reg   <= 1'b0;
        alt_on_reg <= pend_alt_reg;
      end
      if (alt_sw && (act_reg == 1'b1) && !sw_reg[`SCG_B_SW_REPEAT]) begin
        alt_on_reg <= 1'b0; // single pass ends back in bank 0
      end
      if (ctrl_reg[`SCG_B_ALT_STOP]) begin
        alt_on_reg <= 1'b0;
      end
      if (ap_start) begin
        ap_busy_reg <= 1'b1;
        ap_idx_reg  <= ap_b;
        ap_end_reg  <= ap_b + cnt_reg[ap_g];
        act_reg     <= ap_g;
        fc_reg[ap_g] <= 8'h00;
      end else if (ap_go) begin
        ap_idx_reg <= ap_idx_reg + 8'h01;
        if ((ap_idx_reg + 8'h01) >= ap_end_reg) begin
          ap_busy_reg <= 1'b0;
        end
      end else if (ap_busy_reg && (ap_idx_reg >= ap_end_reg)) begin
        ap_busy_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // the pin only ever pulls low; zero is held in a flop for a clean output
  always_ff @(posedge clock_i) begin
    if (rst_any) begin
      serial_data_line_o    <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
      group_active_o        <= 1'b0;
      live_wr_o             <= '0;
    end else begin
      serial_data_line_o    <= 1'b0;
      serial_data_line_oe_o <= oe_reg;
      group_active_o        <= act_reg;
      live_wr_o             <= lw;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_any);

  property p_id_default;
    $fell(rst_any) |-> (prim_id_reg == 8'hc0) && (sec_id_reg == 8'he0);
  endproperty
  a_id_default: assert property (p_id_default) else $error("ids not at default");

  property p_miss_release;
    (rx_done && (idx_reg == 2'h0) && !id_hit) |=> (st_reg == scg_pkg::BUS_IDLE) && !oe_reg;
  endproperty
  a_miss_release: assert property (p_miss_release) else $error("acked foreign id");

  property p_wr_inc;
    bus_wr |=> ptr_reg == $past(ptr_reg) + 16'h0001;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("no pointer step on write");

  property p_rd_inc;
    ((st_reg == scg_pkg::BUS_TX_ACK) && scl_rise && !bus_start && !bus_stop)
      |=> ptr_reg == $past(ptr_reg) + 16'h0001;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("no pointer step on read");

  property p_rec_buf;
    (bus_wr && !cmd_wr && rec_on_reg) |-> !lw.valid || (lw.addr != ptr_reg) || ap_go;
  endproperty
  a_rec_buf: assert property (p_rec_buf) else $error("recorded write hit live");

  sequence s_launch;
    fp_g && pend_reg;
  endsequence
  sequence s_apply_start;
    ap_busy_reg && (ap_idx_reg == $past(ap_b));
  endsequence
  property p_launch;
    s_launch ##0 (cnt_reg[pend_grp_reg] != 8'h00) |=> s_apply_start;
  endproperty
  a_launch: assert property (p_launch) else $error("launch not applied");

  property p_immediate;
    imm |=> ap_busy_reg && (act_reg == $past(rx_byte[0]));
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate apply late");

  property p_stop_alt;
    ctrl_reg[1] |=> !alt_on_reg;
  endproperty
  a_stop_alt: assert property (p_stop_alt) else $error("alternation not stopped");

  property p_oe_state;
    oe_reg |-> (st_reg inside {scg_pkg::BUS_RX_ACK, scg_pkg::BUS_TX, scg_pkg::BUS_RX});
  endproperty
  a_oe_state: assert property (p_oe_state) else $error("line driven out of turn");

endmodule : scg_top

`default_nettype wire

// ==== dv/scg_host_model.sv ====
/* host model of the two-wire control bus: start, stop, byte transfers.
   assumes: the bench resolves the data line with a pull-up. */
`default_nettype none
module scg_host_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released; a slow host keeps the device's sync margin wide
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // one quarter bit per step, pins move only on the clock edge
  task automatic step(input logic c, input logic d);
    repeat (12) @(posedge clock_i);
    scl_o     <= c;
    sda_low_o <= d;
  endtask : step
  // data changes only while the clock is low
  task automatic send_bit(input logic b, output logic s);
    step(1'b0, sda_low_o);
    step(1'b0, !b);
    step(1'b1, !b);
    repeat (12) @(posedge clock_i);
    s = sda_i;
  endtask : send_bit
  // also serves as repeated start
  task automatic start();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop
  // msb first, then the acknowledge slot; ai high releases it
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ao);
    for (int i = 7; i >= 0; i--) send_bit(tx[i], rx[i]);
    send_bit(ai, ao);
  endtask : xfer
endmodule : scg_host_model
`default_nettype wire

// ==== dv/testbench.sv ====
/* self-checking bench of the control slave with its group engine.
   assumes: design, package and host model compiled first. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rst_i = 1'b1, frame_clk_i = 1'b0, frame_start_i = 1'b0;
  logic sda_o, sda_oe, active, k, blank = 1'b0;
  logic [7:0] rx;
  wire logic scl, host_low;
  wire logic sda = !(host_low | sda_oe);
  scg_pkg::scg_wr_t live;
  scg_pkg::scg_entry_t exp_q[$];
  int bad_count = 0, comparisons = 0, cycles = 0, seed = 71;
  initial forever #4 clock_i = !clock_i;
  initial #1.3 forever #3 frame_clk_i = !frame_clk_i;
  scg_top scg_top_i (.clock_i(clock_i), .rst_i(rst_i), .frame_clk_i(frame_clk_i),
    .frame_start_i(frame_start_i), .long_blank_i(blank), .hardware_shutdown_reset_n_i(1'b1),
    .serial_clock_line_i(scl), .serial_data_line_i(sda), .serial_data_line_o(sda_o),
    .serial_data_line_oe_o(sda_oe), .group_active_o(active), .live_wr_o(live));
  scg_host_model scg_host_model_i (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // n data bytes after the sub-address; n of 0 leaves the bus for a repeated start
  task automatic wr(input logic [7:0] id, input logic [15:0] a, input logic [15:0] d, input int n);
    logic [39:0] b;
    b = {id, a, d};
    scg_host_model_i.start();
    for (int i = 0; i < 3 + n; i++) begin
      scg_host_model_i.xfer(b[39-8*i -: 8], 1'b1, rx, k);
      chk("write ack", 24'h0, {23'h0, k});
    end
    if (n > 0) scg_host_model_i.stop();
  endtask : wr
  task automatic rd(input logic [15:0] e, input int n);
    scg_host_model_i.start();
    scg_host_model_i.xfer(8'hc1, 1'b1, rx, k);
    chk("read ack", 24'h0, {23'h0, k});
    for (int i = 0; i < n; i++) begin
      scg_host_model_i.xfer(8'hff, i == n - 1, rx, k);
      chk("read data", {16'h0, e[15-8*i -: 8]}, {16'h0, rx});
    end
    scg_host_model_i.stop();
  endtask : rd
  // live writes of control addresses are not logged, only data registers
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles > 80000) begin
      bad_count++;
      complete_run();
    end
    if (live.valid === 1'b1 && live.addr[15:12] !== 4'h3) begin
      if (exp_q.size() == 0) chk("live write", 24'hxxxxxx, {live.addr, live.data});
      else chk("live write", exp_q.pop_front(), {live.addr, live.data});
    end
  end
  initial begin
    logic [15:0] d;
    d = 16'($random(seed));
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    exp_q.push_back({16'h1234, d[15:8]});
    exp_q.push_back({16'h1235, d[7:0]});
    wr(8'hc0, 16'h1234, d, 2);
    wr(8'hc0, 16'h1234, d, 0);
    rd(d, 2);
    rd(16'h0, 1);
    scg_host_model_i.start();
    scg_host_model_i.xfer(8'h42, 1'b1, rx, k);
    chk("foreign id", 24'h1, {23'h0, k});
    scg_host_model_i.stop();
    exp_q.push_back({16'h1240, d[15:8]});
    wr(8'he0, 16'h1240, d, 1);
    wr(8'hc0, 16'h3208, 16'h0000, 1);
    wr(8'hc0, 16'h4567, 16'ha500, 1);
    wr(8'hc0, 16'h3208, 16'h1000, 1);
    exp_q.push_back(24'h4567a5);
    wr(8'hc0, 16'h3208, 16'ha000, 1);
    @(posedge frame_clk_i) frame_start_i <= 1'b1;
    repeat (4) @(posedge frame_clk_i);
    frame_start_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    chk("active bank", 24'h0, {23'h0, active});
    wr(8'hc0, 16'h3208, 16'h0100, 1);
    wr(8'hc0, 16'h4568, {d[7:0], 8'h00}, 1);
    wr(8'hc0, 16'h3208, 16'h1100, 1);
    exp_q.push_back({16'h4568, d[7:0]});
    wr(8'hc0, 16'h3208, 16'he100, 1);
    repeat (60) @(posedge clock_i);
    chk("active bank", 24'h1, {23'h0, active});
    wr(8'hc0, 16'h301c, 16'h0200, 1);
    wr(8'hc0, 16'h301c, 16'h0000, 1);
    // long blanking without the keep bit: a pending launch must not apply
    @(posedge frame_clk_i) blank <= 1'b1;
    wr(8'hc0, 16'h3208, 16'ha000, 1);
    @(posedge frame_clk_i) frame_start_i <= 1'b1;
    repeat (4) @(posedge frame_clk_i);
    frame_start_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    chk("blank hold", 24'h1, {23'h0, active});
    chk("drive level", 24'h0, {23'h0, sda_o});
    chk("log left", 24'h0, 24'(exp_q.size()));
    complete_run();
  end
endmodule : testbench
`default_nettype wire
